// file: logic/bwc_pkg.sv
package bwc_pkg;

	// =====================================================================
	// Register map: printed indices, byte address is four times the index.
	localparam logic [7:0] IDX_AREA_WIDTH_CTRL = 8'hEC;
	localparam logic [7:0] IDX_AREA_STATE_CTRL = 8'hED;
	localparam logic [7:0] IDX_WAIT_CTRL = 8'hEE;
	localparam logic [7:0] IDX_WAIT_ENABLE_CTRL = 8'hEF;
	localparam int ADDR_W = 12;

	// =====================================================================
	// Reset values and field layout.
	localparam logic [7:0] RST_AREA_STATE = 8'hFF;
	localparam logic [7:0] RST_WAIT_ENABLE = 8'hFF;
	localparam logic [3:0] RST_WAIT_CTRL = 4'h3;
	localparam logic [3:0] WAIT_CTRL_UNUSED = 4'hF;
	localparam int WC_LSB = 0;
	localparam int WMS_LSB = 2;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// =====================================================================
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WM_PROGRAMMABLE,
		WM_NONE,
		WM_PIN1,
		WM_PIN_AUTO
	} bwc_wait_mode_e;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_T1,
		PH_T2,
		PH_TW,
		PH_T3
	} bwc_phase_e;

	// Per-area settings used for one external access.
	typedef struct packed {
		logic width8;
		logic threeState;
		logic waitEnable;
	} bwc_area_cfg_s;

endpackage

// file: logic/bwc_area_bus_wait_control.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps

// Summary of operation
// - An area whose width bit is 0 is accessed 16 bits wide, and 8 bits wide when it is 1.
// - An area whose access-state bit is 0 uses two-state cycles, and three-state when 1.
// - Wait mode 00 is programmable, 01 no controller waits, 10 pin wait 1, 11 pin auto-wait.
// - The wait count field inserts zero, one, two or three wait states.
// - There is one wait enable bit per area, 7 down to 0, each set to 1 by reset.
// - A cleared wait enable bit turns wait control off for its area, giving pin wait mode 0.
module bwc_area_bus_wait_control
	import bwc_pkg::*;
(
	input wire logic mclk, // System clock, 25 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic widthStrap, // Mode strap: 1 makes all areas 8 bits wide after reset.
	input wire logic waitN, // External wait pin, active low, asynchronous.
	input wire logic accStart, // Pulse: begin an external access.
	input wire logic [2:0] accArea, // Area of the access, valid with accStart.
	output logic accBusy, // Access cycle in progress.
	output logic accDone, // Pulse in the last state of an access.
	output logic accWide8, // Current access runs 8 bits wide.
	output bwc_pkg::bwc_phase_e accPhase, // Bus state of the current access.
	input wire logic [bwc_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [bwc_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready // Read data ready.
);
	import bwc_pkg::*;

	// =====================================================================
	// Address decode.
	function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
		byteAddr = {2'b00, idx, 2'b00};
	endfunction

	// =====================================================================
	// Configuration registers.
	logic [7:0] areaWidth;
	logic [7:0] areaState;
	logic [3:0] waitCtrl;
	logic [7:0] waitEnable;
	logic [1:0] strapCnt;
	logic strapDone;

	// =====================================================================
	// Pin synchronisers.
	logic waitS1, waitS2, waitS3, waitLvl;
	logic strapS1, strapS2, strapS3, strapLvl;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{waitS1, waitS2, waitS3} <= 3'h7;
			{strapS1, strapS2, strapS3} <= 3'h0;
		end else begin
			{waitS1, waitS2, waitS3} <= {waitN, waitS1, waitS2};
			{strapS1, strapS2, strapS3} <= {widthStrap, strapS1, strapS2};
		end
	end

	// Levels change only once the second and third stages agree.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			waitLvl <= 1'b1;
			strapLvl <= 1'b0;
		end else begin
			if (waitS2 == waitS3) begin
				waitLvl <= waitS3;
			end
			if (strapS2 == strapS3) begin
				strapLvl <= strapS3;
			end
		end
	end

	wire waitAsserted = ~waitLvl;

	// =====================================================================
	// AXI4-Lite write channel.
	logic awHave, wHave;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic wLane0;

	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire doWrite = awHave & wHave & ~s_axi_bvalid;
	wire wrWidth = awAddr == byteAddr(IDX_AREA_WIDTH_CTRL);
	wire wrState = awAddr == byteAddr(IDX_AREA_STATE_CTRL);
	wire wrWait = awAddr == byteAddr(IDX_WAIT_CTRL);
	wire wrEnable = awAddr == byteAddr(IDX_WAIT_ENABLE_CTRL);
	wire wrHit = wrWidth | wrState | wrWait | wrEnable;
	wire wrGo = doWrite & wLane0;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awHave <= 1'b0;
			wHave <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wLane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (awTake) begin
				awHave <= 1'b1;
				awAddr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (wTake) begin
				wHave <= 1'b1;
				wData <= s_axi_wdata;
				wLane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (doWrite) begin
				awHave <= 1'b0;
				wHave <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// The width register takes its strap value once the strap has settled after reset.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			areaWidth <= '0;
			areaState <= RST_AREA_STATE;
			waitCtrl <= RST_WAIT_CTRL;
			waitEnable <= RST_WAIT_ENABLE;
			strapCnt <= '0;
			strapDone <= 1'b0;
		end else begin
			if (!strapDone) begin
				strapCnt <= strapCnt + 2'h1;
				if (strapCnt == STRAP_SETTLE) begin
					strapDone <= 1'b1;
					// Take the level that the synchroniser settles on at this same edge.
					areaWidth <= {8{(strapS2 == strapS3) ? strapS3 : strapLvl}};
				end
			end
			if (wrGo & wrWidth) begin
				areaWidth <= wData[7:0];
			end
			if (wrGo & wrState) begin
				areaState <= wData[7:0];
			end
			if (wrGo & wrWait) begin
				waitCtrl <= wData[3:0];
			end
			if (wrGo & wrEnable) begin
				waitEnable <= wData[7:0];
			end
		end
	end

	// =====================================================================
	// AXI4-Lite read channel.
	wire arTake = s_axi_arvalid & s_axi_arready;
	wire rdWidth = s_axi_araddr == byteAddr(IDX_AREA_WIDTH_CTRL);
	wire rdState = s_axi_araddr == byteAddr(IDX_AREA_STATE_CTRL);
	wire rdWait = s_axi_araddr == byteAddr(IDX_WAIT_CTRL);
	wire rdEnable = s_axi_araddr == byteAddr(IDX_WAIT_ENABLE_CTRL);
	wire rdHit = rdWidth | rdState | rdWait | rdEnable;
	wire [7:0] rdByte = rdWidth ? areaWidth :
		rdState ? areaState :
		rdWait ? {WAIT_CTRL_UNUSED, waitCtrl} :
		rdEnable ? waitEnable : 8'h00;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (arTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rdByte};
			s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// =====================================================================
	// Access sequencer.
	bwc_area_cfg_s cfg;
	logic [1:0] waitLeft;
	logic pinExtend;

	wire bwc_area_cfg_s startCfg = '{width8: areaWidth[accArea],
		threeState: areaState[accArea], waitEnable: waitEnable[accArea]};
	wire bwc_wait_mode_e waitMode = bwc_wait_mode_e'(waitCtrl[WMS_LSB +: 2]);
	wire [1:0] waitCount = waitCtrl[WC_LSB +: 2];

	// Wait plan decided at the end of T2.
	logic [1:0] planCount;
	logic planPin;
	always_comb begin
		planCount = 2'h0;
		planPin = 1'b0;
		if (!cfg.waitEnable) begin
			planPin = 1'b1;
		end else begin
			unique case (waitMode)
				WM_PROGRAMMABLE: planCount = waitCount;
				WM_NONE: planCount = 2'h0;
				WM_PIN1: begin
					planCount = waitCount;
					planPin = 1'b1;
				end
				WM_PIN_AUTO: planCount = waitAsserted ? waitCount : 2'h0;
			endcase
		end
	end

	wire planMore = (planCount != 2'h0) | (planPin & waitAsserted);
	wire [1:0] twLeft = (waitLeft == 2'h0) ? 2'h0 : waitLeft - 2'h1;
	wire twMore = (twLeft != 2'h0) | (pinExtend & waitAsserted);

	bwc_phase_e next_accPhase;
	always_comb begin
		next_accPhase = accPhase;
		unique case (accPhase)
			PH_IDLE: next_accPhase = accStart ? PH_T1 : PH_IDLE;
			PH_T1: next_accPhase = PH_T2;
			PH_T2: begin
				if (!cfg.threeState) begin
					next_accPhase = PH_IDLE;
				end else begin
					next_accPhase = planMore ? PH_TW : PH_T3;
				end
			end
			PH_TW: next_accPhase = twMore ? PH_TW : PH_T3;
			PH_T3: next_accPhase = PH_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			accPhase <= PH_IDLE;
			cfg <= '0;
			waitLeft <= '0;
			pinExtend <= 1'b0;
			accBusy <= 1'b0;
			accDone <= 1'b0;
			accWide8 <= 1'b0;
		end else begin
			accPhase <= next_accPhase;
			accBusy <= next_accPhase != PH_IDLE;
			accDone <= (accPhase == PH_T1 && !cfg.threeState) ||
				(next_accPhase == PH_T3);
			if (accPhase == PH_IDLE && accStart) begin
				cfg <= startCfg;
				accWide8 <= startCfg.width8;
			end
			if (accPhase == PH_T2) begin
				waitLeft <= planCount;
				pinExtend <= planPin;
			end else if (accPhase == PH_TW) begin
				waitLeft <= twLeft;
			end
		end
	end

endmodule

// file: bench/bwc_checker_sva.sv
`timescale 1ns/100ps
module bwc_checker
	import bwc_pkg::*;
(
	input wire logic mclk, // Clock.
	input wire logic rst, // Reset.
	input wire logic accStart, // Start pulse.
	input wire logic accBusy, // Busy level.
	input wire logic accDone, // Last state.
	input wire logic accWide8, // Width.
	input wire bwc_pkg::bwc_phase_e accPhase // Phase.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_busy; accBusy == (accPhase != PH_IDLE); endproperty
	a_busy: assert property (p_busy) else $error("busy flag off");
	property p_start; accStart && accPhase == PH_IDLE |=> accPhase == PH_T1; endproperty
	a_start: assert property (p_start) else $error("no T1");
	property p_t1; accPhase == PH_T1 |=> accPhase == PH_T2; endproperty
	a_t1: assert property (p_t1) else $error("no T2");
	property p_done; accDone |-> (accPhase == PH_T2 || accPhase == PH_T3) ##1 !accDone; endproperty
	a_done: assert property (p_done) else $error("bad done");
	property p_end; accPhase == PH_T2 && accDone |=> accPhase == PH_IDLE; endproperty
	a_end: assert property (p_end) else $error("two-state ran on");
	property p_tw; accPhase == PH_TW |-> $past(accPhase) inside {PH_T2, PH_TW}; endproperty
	a_tw: assert property (p_tw) else $error("stray wait");
	property p_ign; accBusy && accStart |=> accPhase != PH_T1; endproperty
	a_ign: assert property (p_ign) else $error("restart while busy");
	property p_wide; accBusy && $past(accBusy) |-> $stable(accWide8); endproperty
	a_wide: assert property (p_wide) else $error("width moved");
endmodule
bind bwc_area_bus_wait_control bwc_checker u_chk (.mclk(mclk), .rst(rst), .accStart(accStart),
	.accBusy(accBusy), .accDone(accDone), .accWide8(accWide8), .accPhase(accPhase));

// file: bench/bwc_mem_model.sv
`timescale 1ns/100ps
module bwc_mem_model (
	input wire logic mclk, // Clock.
	input wire logic accBusy, // Access under way.
	input wire logic slow, // Peripheral is slow.
	input wire logic [7:0] holdCycles, // Busy cycles it needs.
	output logic waitN // Wait pin, pulled up.
);
	logic [7:0] busyCnt = 8'h00;
	always @(posedge mclk) busyCnt <= accBusy ? busyCnt + 8'h01 : 8'h00;
	// A slow peripheral holds the pin low until it has seen enough busy cycles.
	assign waitN = !(slow && busyCnt < holdCycles);
endmodule

// file: bench/test_area_bus_wait_control.sv
`timescale 1ns/100ps
module test_area_bus_wait_control;
	import bwc_pkg::*;
	logic mclk = 0, rst = 1, strap = 1, waitN, accStart = 0, slow = 0, accBusy, accDone, w8;
	logic [2:0] ar = 0;
	logic [7:0] wid, st, en, wc;
	logic accWide8, awready, wready, bvalid, arready, rvalid, awvalid = 0, wvalid = 0, arvalid = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp;
	bwc_phase_e accPhase;
	int fail_count = 0, compares = 0, t, len, x, nd;
	bwc_area_bus_wait_control u_dut (.mclk(mclk), .rst(rst), .widthStrap(strap), .waitN(waitN),
		.accStart(accStart), .accArea(ar), .accBusy(accBusy), .accDone(accDone),
		.accWide8(accWide8), .accPhase(accPhase), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
	bwc_mem_model u_mem (.mclk(mclk), .accBusy(accBusy), .slow(slow), .holdCycles(8'd14),
		.waitN(waitN));
	initial forever #20 mclk = ~mclk;
	// ========
	// Checking and bus tasks.
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task give_verdict;
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [11:0] ad(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		int i;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		if (i == 50) chk("write wait", 0, 1);
		if (i == 50) give_verdict();
		chk("bresp", bresp, er);
	endtask
	task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] exp,
		input logic [1:0] er);
		int i;
		araddr <= ad(idx);
		arvalid <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		if (i == 50) chk("read wait", 0, 1);
		if (i == 50) give_verdict();
		chk(nm, rdata, exp);
		chk("rresp", rresp, er);
	endtask
	// Start is held into T1 as well, where it must be ignored.
	task automatic acc();
		int i;
		accStart <= 1;
		@(posedge mclk);
		@(posedge mclk);
		accStart <= 0;
		len = accBusy ? 1 : 0;
		nd = 0;
		for (i = 0; i < 60; i++) begin
			@(posedge mclk);
			if (accBusy) len++;
			if (accDone) nd++;
			if (accBusy) w8 = accWide8;
			else if (len > 0) break;
		end
		if (i == 60) chk("access wait", 0, 1);
		if (i == 60) give_verdict();
	endtask
	// Negative result: the access must run longer than its magnitude.
	function automatic int exp_len(input logic s, e, p, input logic [3:0] w);
		if (!s) return 2;
		if (!e) return p ? -3 : 3;
		case (w[3:2])
			2'd0: return 3 + w[1:0];
			2'd1: return 3;
			2'd2: return p ? -(3 + w[1:0]) : 3 + w[1:0];
			default: return p ? 3 + w[1:0] : 3;
		endcase
	endfunction
	// ========
	// Main sequence.
	initial begin
		void'($urandom(40));
		repeat (20) @(posedge mclk);
		rst <= 0;
		repeat (5) @(posedge mclk);
		rc("width", IDX_AREA_WIDTH_CTRL, 32'hFF, RESP_OKAY);
		rc("state", IDX_AREA_STATE_CTRL, 32'hFF, RESP_OKAY);
		rc("waitc", IDX_WAIT_CTRL, 32'hF3, RESP_OKAY);
		rc("wen", IDX_WAIT_ENABLE_CTRL, 32'hFF, RESP_OKAY);
		rc("hole", 8'hF0, 32'h0, RESP_SLVERR);
		wr(ad(8'hF0), 8'h00, RESP_SLVERR);
		$display("reset test done");
		for (t = 0; t < 48; t++) begin
			wid = $urandom;
			st = $urandom;
			en = $urandom;
			wc = t < 16 ? 8'(t) : 8'($urandom);
			ar <= 3'($urandom);
			slow <= t[4];
			wr(ad(IDX_AREA_WIDTH_CTRL), wid, RESP_OKAY);
			wr(ad(IDX_AREA_STATE_CTRL), st, RESP_OKAY);
			wr(ad(IDX_WAIT_CTRL), wc, RESP_OKAY);
			wr(ad(IDX_WAIT_ENABLE_CTRL), en, RESP_OKAY);
			rc("waitc", IDX_WAIT_CTRL, {24'h0, 4'hF, wc[3:0]}, RESP_OKAY);
			rc("state", IDX_AREA_STATE_CTRL, {24'h0, st}, RESP_OKAY);
			x = exp_len(st[ar], en[ar], t[4], wc[3:0]);
			repeat (t[4] ? 1 : 2) begin
				acc();
				chk("wide", w8, wid[ar]);
				chk("done", nd, 1);
				if (x >= 0) chk("length", len, x);
				else chk("long", len > -x, 1);
			end
		end
		$display("access test done");
		rst <= 1;
		strap <= 0;
		repeat (20) @(posedge mclk);
		rst <= 0;
		repeat (5) @(posedge mclk);
		rc("width", IDX_AREA_WIDTH_CTRL, 32'h00, RESP_OKAY);
		rc("wen", IDX_WAIT_ENABLE_CTRL, 32'hFF, RESP_OKAY);
		$display("second reset test done");
		give_verdict();
	end
endmodule
